// file: rtl/ata_wr_consts.vh
// Constants for the ATA power and write command engine.
`ifndef ATA_WR_CONSTS_VH
`define ATA_WR_CONSTS_VH

// ****************************************************************
// Register indices on the plain register port
// ****************************************************************
`define REG_DATA 4'h0
`define REG_FEAT_ERR 4'h1
`define REG_SCOUNT 4'h2
`define REG_LBA_LOW 4'h3
`define REG_LBA_MID 4'h4
`define REG_LBA_HIGH 4'h5
`define REG_DRV_HEAD 4'h6
`define REG_CMD_STAT 4'h7
`define REG_DEV_CTRL 4'h8
`define REG_CONFIG 4'h9
`define REG_IDENT82 4'hA

// ****************************************************************
// Command opcodes
// ****************************************************************
`define CMD_SMART 8'hB0
`define CMD_STBY_A 8'h96
`define CMD_STBY_B 8'hE2
`define CMD_STBY_IMM_A 8'h94
`define CMD_STBY_IMM_B 8'hE0
`define CMD_TRANSLATE 8'h87
`define CMD_WR_BUF 8'hE8
`define CMD_WR_DMA_A 8'hCA
`define CMD_WR_DMA_B 8'hCB
`define CMD_WR_DMA_EXT 8'h35

// ****************************************************************
// Signatures, fields and reset values
// ****************************************************************
`define SMART_SIG_HI 8'hC2
`define SMART_SIG_LO 8'h4F
`define IDENT82_VAL 16'h0001
`define BIT_BSY 7
`define BIT_DRDY 6
`define BIT_DRQ 3
`define BIT_ERR 0
`define BIT_ABRT 2
`define BIT_UNC 6
`define BIT_HOB 7
`define BIT_LBA_MODE 6
`define BIT_EIGHT 0
`define BYTE_ZERO 8'h00
`define WORD_LAST 8'hFF
`define WORD_FIRST 8'h00
`define SECTORS_28 17'h0_0100
`define SECTORS_48 17'h1_0000
`define ONE_SECTOR 17'h0_0001
`define LBA_STEP 48'h0000_0000_0001

`endif

// file: rtl/sector_buffer.v
// One-sector buffer of 256 words with a registered read port.
`timescale 1ns/10ps
module sector_buffer (
    // Clock
    input wire core_clk,
    // Write port
    input wire wr_en,
    input wire [7:0] wr_addr,
    input wire [15:0] wr_data,
    // Read port
    input wire [7:0] rd_addr,
    output reg [15:0] rd_data
);
    reg [15:0] mem [0:255];

    always @(posedge core_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule

// file: rtl/ata_wr_engine.v
// Command engine for SMART entry, standby, translate, write buffer and DMA writes.
// What this block does
// - SMART opcode B0h needs C2h/4Fh in cylinder high/low; the feature register is not decoded.
// - Identify word 82 bit 0 reports SMART support.
// - Standby 96h/E2h sets BSY, sleeps, clears BSY and interrupts at once.
// - Standby Immediate 94h/E0h sets BSY, sleeps, clears BSY, interrupts immediately.
// - Any further command wakes the device from sleep.
// - Translate Sector 87h is a no-op returning sector count 00h.
// - Write Buffer E8h takes 512 bytes by PIO into the sector buffer.
// - Write DMA CAh/CBh moves 1 to 256 sectors; count zero means 256.
// - A DMA write starts at the address held in the command block registers.
// - On a DMA write set BSY, prepare buffer, then set DRQ and clear BSY.
// - DMARQ is high only while the device can accept write data.
// - A DMA write interrupts only on full completion or unrecoverable error.
// - After success the registers hold the address of the last sector written.
// - On error the write stops and the registers hold the failing sector address.
// - With 8-bit transfer mode enabled a DMA write is aborted.
// - Write DMA Ext 35h uses 48-bit LBA and 16-bit count; zero means 65536.
// - The 48-bit write reports last written or failing LBA.
// - HOB in device control selects the high-order byte of sector count and LBA low/mid/high on reads.
`timescale 1ns/10ps
`include "ata_wr_consts.vh"
module ata_wr_engine (
    // Clock and reset
    input wire core_clk,
    input wire nrst,
    // Register port
    input wire [3:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [15:0] reg_rdata_q,
    // DMA handshake
    output reg dmarq_q,
    input wire dmack,
    input wire iowr,
    input wire [15:0] dma_data,
    // Media side
    output reg sector_wr_q,
    output reg [47:0] sector_lba_q,
    input wire media_err,
    input wire [7:0] media_raddr,
    output wire [15:0] media_rdata,
    // Status
    output reg intrq_q,
    output reg bsy_q,
    output reg drq_q,
    output reg sleep_q
);
    localparam [2:0] ST_IDLE = 3'd0;
    localparam [2:0] ST_STBY = 3'd1;
    localparam [2:0] ST_PREP = 3'd2;
    localparam [2:0] ST_DMA = 3'd3;
    localparam [2:0] ST_PIO = 3'd4;
    localparam [2:0] ST_COMMIT = 3'd5;

    // ****************************************************************
    // Reset release
    // ****************************************************************
    reg rst_s1_q;
    reg rst_n_q;
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rst_s1_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n_q <= rst_s1_q;
        end
    end

    // ****************************************************************
    // State
    // ****************************************************************
    reg [2:0] state_q;
    reg [7:0] feat_q;
    reg [7:0] err_q;
    reg [15:0] scount_q;
    reg [15:0] lba_lo_q;
    reg [15:0] lba_mid_q;
    reg [15:0] lba_hi_q;
    reg [7:0] drv_q;
    reg hob_q;
    reg eight_bit_q;
    reg stat_err_q;
    reg [7:0] word_q;
    reg [16:0] remain_q;
    reg [47:0] addr_q;
    reg ext_q;
    reg buf_wr;
    reg [15:0] buf_wdata;

    wire [7:0] status = {bsy_q, ~bsy_q, 2'b00, drq_q, 2'b00, stat_err_q};
    wire is_cmd = reg_wr && (reg_addr == `REG_CMD_STAT);
    wire [7:0] opc = reg_wdata[7:0];
    wire dma_word = (state_q == ST_DMA) && dmarq_q && dmack && iowr;
    wire pio_word = (state_q == ST_PIO) && reg_wr && (reg_addr == `REG_DATA);
    wire [47:0] lba_now = {lba_hi_q[15:8], lba_mid_q[15:8], lba_lo_q[15:8],
                           lba_hi_q[7:0], lba_mid_q[7:0], lba_lo_q[7:0]};
    wire [47:0] lba_28 = {20'h0_0000, drv_q[3:0], lba_hi_q[7:0], lba_mid_q[7:0],
                          lba_lo_q[7:0]};
    wire [47:0] addr_next = addr_q + `LBA_STEP;

    always @* begin
        buf_wr = dma_word | pio_word;
        buf_wdata = dma_word ? dma_data : reg_wdata;
    end

    sector_buffer u_buf (
        .core_clk(core_clk),
        .wr_en(buf_wr),
        .wr_addr(word_q),
        .wr_data(buf_wdata),
        .rd_addr(media_raddr),
        .rd_data(media_rdata)
    );

    // ****************************************************************
    // Register reads
    // ****************************************************************
    reg [7:0] rd_byte;
    always @* begin
        rd_byte = `BYTE_ZERO;
        case (reg_addr)
            `REG_FEAT_ERR: rd_byte = err_q;
            `REG_SCOUNT: rd_byte = hob_q ? scount_q[15:8] : scount_q[7:0];
            `REG_LBA_LOW: rd_byte = hob_q ? lba_lo_q[15:8] : lba_lo_q[7:0];
            `REG_LBA_MID: rd_byte = hob_q ? lba_mid_q[15:8] : lba_mid_q[7:0];
            `REG_LBA_HIGH: rd_byte = hob_q ? lba_hi_q[15:8] : lba_hi_q[7:0];
            `REG_DRV_HEAD: rd_byte = drv_q;
            `REG_CMD_STAT: rd_byte = status;
            `REG_DEV_CTRL: rd_byte = {hob_q, 7'h00};
            `REG_CONFIG: rd_byte = {7'h00, eight_bit_q};
            default: rd_byte = `BYTE_ZERO;
        endcase
    end

    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            reg_rdata_q <= 16'h0000;
        end else if (!rst_n_q) begin
            reg_rdata_q <= 16'h0000;
        end else if (reg_rd) begin
            if (reg_addr == `REG_IDENT82) begin
                reg_rdata_q <= `IDENT82_VAL;
            end else begin
                reg_rdata_q <= {8'h00, rd_byte};
            end
        end else begin
            reg_rdata_q <= 16'h0000;
        end
    end

    // ****************************************************************
    // Command engine and task file
    // ****************************************************************
    // A sector count or LBA register write shifts the current byte into the previous byte, so
    // the host loads the high-order bytes first and the low-order ones after.
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            state_q <= ST_IDLE;
            feat_q <= 8'h00;
            err_q <= 8'h00;
            scount_q <= 16'h0000;
            lba_lo_q <= 16'h0000;
            lba_mid_q <= 16'h0000;
            lba_hi_q <= 16'h0000;
            drv_q <= 8'h00;
            hob_q <= 1'b0;
            eight_bit_q <= 1'b0;
            stat_err_q <= 1'b0;
            word_q <= `WORD_FIRST;
            remain_q <= 17'h0_0000;
            addr_q <= 48'h0000_0000_0000;
            ext_q <= 1'b0;
            intrq_q <= 1'b0;
            bsy_q <= 1'b0;
            drq_q <= 1'b0;
            sleep_q <= 1'b0;
            dmarq_q <= 1'b0;
            sector_wr_q <= 1'b0;
            sector_lba_q <= 48'h0000_0000_0000;
        end else if (!rst_n_q) begin
            state_q <= ST_IDLE;
            intrq_q <= 1'b0;
            bsy_q <= 1'b0;
            drq_q <= 1'b0;
            dmarq_q <= 1'b0;
            sector_wr_q <= 1'b0;
        end else begin
            sector_wr_q <= 1'b0;
            // Reading status acknowledges the interrupt; a new one wins below.
            if (reg_rd && (reg_addr == `REG_CMD_STAT)) begin
                intrq_q <= 1'b0;
            end
            if (reg_wr && !bsy_q) begin
                case (reg_addr)
                    `REG_FEAT_ERR: feat_q <= reg_wdata[7:0];
                    `REG_SCOUNT: scount_q <= {scount_q[7:0], reg_wdata[7:0]};
                    `REG_LBA_LOW: lba_lo_q <= {lba_lo_q[7:0], reg_wdata[7:0]};
                    `REG_LBA_MID: lba_mid_q <= {lba_mid_q[7:0], reg_wdata[7:0]};
                    `REG_LBA_HIGH: lba_hi_q <= {lba_hi_q[7:0], reg_wdata[7:0]};
                    `REG_DRV_HEAD: drv_q <= reg_wdata[7:0];
                    `REG_CONFIG: eight_bit_q <= reg_wdata[`BIT_EIGHT];
                    default: begin
                    end
                endcase
            end
            if (reg_wr && (reg_addr == `REG_DEV_CTRL)) begin
                hob_q <= reg_wdata[`BIT_HOB];
            end else if ((reg_wr || reg_rd) && (reg_addr != `REG_DATA)) begin
                hob_q <= 1'b0;
            end
            case (state_q)
                ST_IDLE: begin
                    if (is_cmd) begin
                        sleep_q <= 1'b0;
                        err_q <= 8'h00;
                        stat_err_q <= 1'b0;
                        word_q <= `WORD_FIRST;
                        case (opc)
                            `CMD_STBY_A, `CMD_STBY_B, `CMD_STBY_IMM_A, `CMD_STBY_IMM_B: begin
                                bsy_q <= 1'b1;
                                state_q <= ST_STBY;
                            end
                            `CMD_TRANSLATE: begin
                                scount_q <= 16'h0000;
                                intrq_q <= 1'b1;
                            end
                            `CMD_SMART: begin
                                // Sub-functions live elsewhere; only the signature is checked.
                                if (lba_hi_q[7:0] != `SMART_SIG_HI ||
                                    lba_mid_q[7:0] != `SMART_SIG_LO) begin
                                    err_q[`BIT_ABRT] <= 1'b1;
                                    stat_err_q <= 1'b1;
                                end
                                intrq_q <= 1'b1;
                            end
                            `CMD_WR_BUF: begin
                                drq_q <= 1'b1;
                                state_q <= ST_PIO;
                            end
                            `CMD_WR_DMA_A, `CMD_WR_DMA_B, `CMD_WR_DMA_EXT: begin
                                if (eight_bit_q) begin
                                    err_q[`BIT_ABRT] <= 1'b1;
                                    stat_err_q <= 1'b1;
                                    intrq_q <= 1'b1;
                                end else begin
                                    bsy_q <= 1'b1;
                                    ext_q <= (opc == `CMD_WR_DMA_EXT);
                                    if (opc == `CMD_WR_DMA_EXT) begin
                                        addr_q <= lba_now;
                                        remain_q <= (scount_q == 16'h0000) ? `SECTORS_48 :
                                                    {1'b0, scount_q};
                                    end else begin
                                        addr_q <= lba_28;
                                        remain_q <= (scount_q[7:0] == `BYTE_ZERO) ?
                                                    `SECTORS_28 : {9'h000, scount_q[7:0]};
                                    end
                                    state_q <= ST_PREP;
                                end
                            end
                            default: begin
                                err_q[`BIT_ABRT] <= 1'b1;
                                stat_err_q <= 1'b1;
                                intrq_q <= 1'b1;
                            end
                        endcase
                    end
                end
                ST_STBY: begin
                    sleep_q <= 1'b1;
                    bsy_q <= 1'b0;
                    intrq_q <= 1'b1;
                    state_q <= ST_IDLE;
                end
                ST_PREP: begin
                    bsy_q <= 1'b0;
                    drq_q <= 1'b1;
                    dmarq_q <= 1'b1;
                    state_q <= ST_DMA;
                end
                ST_PIO: begin
                    if (pio_word) begin
                        word_q <= word_q + 8'h01;
                        if (word_q == `WORD_LAST) begin
                            drq_q <= 1'b0;
                            intrq_q <= 1'b1;
                            state_q <= ST_IDLE;
                        end
                    end
                end
                ST_DMA: begin
                    if (dma_word) begin
                        word_q <= word_q + 8'h01;
                        if (word_q == `WORD_LAST) begin
                            // Hold off the host while the sector is committed.
                            dmarq_q <= 1'b0;
                            bsy_q <= 1'b1;
                            drq_q <= 1'b0;
                            sector_wr_q <= 1'b1;
                            sector_lba_q <= addr_q;
                            state_q <= ST_COMMIT;
                        end
                    end
                end
                ST_COMMIT: begin
                    // Media error is sampled at the edge that ends the commit pulse.
                    bsy_q <= 1'b0;
                    if (media_err || remain_q == `ONE_SECTOR) begin
                        // Address is failing or last sector either way.
                        lba_lo_q <= {addr_q[31:24], addr_q[7:0]};
                        lba_mid_q <= {addr_q[39:32], addr_q[15:8]};
                        lba_hi_q <= {addr_q[47:40], addr_q[23:16]};
                        if (!ext_q) begin
                            drv_q[3:0] <= addr_q[27:24];
                        end
                        if (media_err) begin
                            err_q[`BIT_UNC] <= 1'b1;
                            stat_err_q <= 1'b1;
                        end
                        intrq_q <= 1'b1;
                        state_q <= ST_IDLE;
                    end else begin
                        addr_q <= addr_next;
                        remain_q <= remain_q - `ONE_SECTOR;
                        drq_q <= 1'b1;
                        dmarq_q <= 1'b1;
                        state_q <= ST_DMA;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end
endmodule

// file: bench/ata_wr_engine_chk.sv
// Assertion checker bound to the ATA power and write command engine.
`timescale 1ns/10ps
`include "ata_wr_consts.vh"
module ata_wr_engine_chk (
    // Clock and reset
    input wire core_clk,
    input wire nrst,
    // Register port
    input wire [3:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_wr,
    // DMA handshake and media
    input wire dmarq_q,
    input wire dmack,
    input wire iowr,
    input wire sector_wr_q,
    input wire media_err,
    // Status
    input wire intrq_q,
    input wire bsy_q,
    input wire drq_q,
    input wire sleep_q
);
    logic eight_q;
    logic [8:0] words_q;
    wire [7:0] op = reg_wdata[7:0];
    wire cmd_wr = reg_wr && reg_addr == `REG_CMD_STAT && !bsy_q && !drq_q;
    wire is_stby = op == `CMD_STBY_A || op == `CMD_STBY_B || op == `CMD_STBY_IMM_A
        || op == `CMD_STBY_IMM_B;
    wire is_dma = op == `CMD_WR_DMA_A || op == `CMD_WR_DMA_B || op == `CMD_WR_DMA_EXT;

    // ****************************************************************
    // Helper state
    // ****************************************************************
    // Words taken since the last sector hand-off; a sector must close on exactly 256.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            eight_q <= 1'b0;
            words_q <= 9'h000;
        end else begin
            if (reg_wr && reg_addr == `REG_CONFIG && !bsy_q) begin
                eight_q <= reg_wdata[`BIT_EIGHT];
            end
            if (sector_wr_q) begin
                words_q <= 9'h000;
            end else if (dmarq_q && dmack && iowr) begin
                words_q <= words_q + 9'h001;
            end
        end
    end

    // ****************************************************************
    // Properties
    // ****************************************************************
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);
    sequence s_enter_sleep;
        bsy_q ##1 (!bsy_q && sleep_q && intrq_q);
    endsequence
    sequence s_dma_ready;
        bsy_q ##1 (!bsy_q && drq_q && dmarq_q);
    endsequence
    property p_standby; cmd_wr && is_stby |=> s_enter_sleep; endproperty
    property p_wake; reg_wr && reg_addr == `REG_CMD_STAT && sleep_q && !bsy_q |=> !sleep_q;
    endproperty
    property p_translate; cmd_wr && op == `CMD_TRANSLATE |=> intrq_q; endproperty
    property p_smart; cmd_wr && op == `CMD_SMART |=> intrq_q; endproperty
    property p_wbuf; cmd_wr && op == `CMD_WR_BUF |=> drq_q && !intrq_q; endproperty
    property p_dma_go; cmd_wr && is_dma && !eight_q |=> s_dma_ready; endproperty
    property p_dma_abort; cmd_wr && is_dma && eight_q |=> (intrq_q && !dmarq_q) [*2];
    endproperty
    property p_dmarq_state; dmarq_q |-> drq_q && !bsy_q; endproperty
    property p_sector_words; sector_wr_q |-> words_q == 9'h100 && !dmarq_q && bsy_q;
    endproperty
    property p_err_stop;
        sector_wr_q && media_err |=> (intrq_q && !dmarq_q && !drq_q && !bsy_q) ##1 !dmarq_q;
    endproperty
    property p_irq_quiet; dmarq_q |-> !$rose(intrq_q); endproperty
    a_standby: assert property (p_standby) else $error("standby sequence wrong");
    a_wake: assert property (p_wake) else $error("sleep kept after command");
    a_translate: assert property (p_translate) else $error("translate no irq");
    a_smart: assert property (p_smart) else $error("smart no irq");
    a_wbuf: assert property (p_wbuf) else $error("write buffer no drq");
    a_dma_go: assert property (p_dma_go) else $error("dma start wrong");
    a_dma_abort: assert property (p_dma_abort) else $error("8-bit dma not aborted");
    a_dmarq_state: assert property (p_dmarq_state) else $error("dmarq outside data phase");
    a_sector_words: assert property (p_sector_words) else $error("sector word count");
    a_err_stop: assert property (p_err_stop) else $error("write not stopped on error");
    a_irq_quiet: assert property (p_irq_quiet) else $error("irq during transfer");
endmodule

bind ata_wr_engine ata_wr_engine_chk u_ata_wr_engine_chk (
    .core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .dmarq_q(dmarq_q), .dmack(dmack), .iowr(iowr),
    .sector_wr_q(sector_wr_q), .media_err(media_err), .intrq_q(intrq_q), .bsy_q(bsy_q),
    .drq_q(drq_q), .sleep_q(sleep_q)
);

// file: bench/dma_host_model.sv
// Host adapter model that answers DMA requests with word strobes.
`timescale 1ns/10ps
module dma_host_model (
    // Clock
    input wire core_clk,
    // Handshake
    input wire dmarq_q,
    output logic dmack,
    output logic iowr,
    output logic [15:0] dma_data
);
    integer seed = 32'h0000_2292;
    // A count of 256 means the sector is complete and the model waits for the
    // request to drop, so that no strobe is ever sent into a request that is closing.
    logic [8:0] n = 9'h000;
    wire go = dmarq_q && n != 9'h100 && !(iowr && n == 9'h0FF);
    initial begin
        dmack = 1'b0;
        iowr = 1'b0;
        dma_data = 16'h0000;
    end
    always @(posedge core_clk) begin
        if (n == 9'h100) begin
            if (!dmarq_q) begin
                n <= 9'h000;
            end
        end else if (iowr) begin
            n <= n + 9'h001;
        end
        dmack <= go;
        if (go && ($random(seed) & 3) != 0) begin
            iowr <= 1'b1;
            dma_data <= 16'($random(seed));
        end else begin
            iowr <= 1'b0;
            dma_data <= ~dma_data;
        end
    end
endmodule

// file: bench/ata_power_and_write_commands_tb_top.sv
// Self-checking testbench for the ATA power and write command engine.
`timescale 1ns/10ps
`include "ata_wr_consts.vh"
module ata_power_and_write_commands_tb_top;
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic media_err = 1'b0;
    logic [7:0] media_raddr = 8'h00;
    logic mrd = 1'b0;
    logic rpend = 1'b0;
    logic mpend = 1'b0;
    logic err_arm = 1'b0;
    wire [15:0] reg_rdata_q, media_rdata, dma_data;
    wire [47:0] sector_lba_q;
    wire dmarq_q, dmack, iowr, sector_wr_q, intrq_q, bsy_q, drq_q, sleep_q;
    integer seed = 32'h0000_2292;
    integer num_errors = 0;
    integer compares = 0;
    logic [7:0] rq[$];
    logic [15:0] mq[$];
    logic [47:0] lq[$];
    logic [15:0] wbuf [0:255];
    logic [7:0] stby [4] = '{`CMD_STBY_A, `CMD_STBY_B, `CMD_STBY_IMM_A, `CMD_STBY_IMM_B};
    logic [7:0] ext_prev [4] = '{8'h00, 8'h9A, 8'h78, 8'h56};
    logic [7:0] ext_cur [4] = '{8'h03, 8'h01, 8'h02, 8'h03};

    ata_wr_engine u_ata_wr_engine (
        .core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .dmarq_q(dmarq_q),
        .dmack(dmack), .iowr(iowr), .dma_data(dma_data), .sector_wr_q(sector_wr_q),
        .sector_lba_q(sector_lba_q), .media_err(media_err), .media_raddr(media_raddr),
        .media_rdata(media_rdata), .intrq_q(intrq_q), .bsy_q(bsy_q), .drq_q(drq_q),
        .sleep_q(sleep_q)
    );
    dma_host_model u_dma_host_model (
        .core_clk(core_clk), .dmarq_q(dmarq_q), .dmack(dmack), .iowr(iowr), .dma_data(dma_data)
    );

    initial begin
        forever #12.5 core_clk = ~core_clk;
    end

    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge core_clk);
        rq.push_back(e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
    endtask
    task automatic mread(input logic [7:0] a);
        @(posedge core_clk);
        mq.push_back(wbuf[a]);
        media_raddr <= a;
        mrd <= 1'b1;
        @(posedge core_clk);
        mrd <= 1'b0;
    endtask
    task automatic wait_irq;
        int k;
        for (k = 0; k < 4000 && intrq_q !== 1'b1; k++) begin
            @(posedge core_clk);
        end
        chk(48'(intrq_q), 48'h0000_0000_0001);
    endtask
    task automatic print_verdict;
        $display("checks %0d errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Each result is compared with the oldest expectation noted by the driver.
    always @(posedge core_clk) begin
        if (rpend) begin
            chk(48'(reg_rdata_q[7:0]), 48'(rq.pop_front()));
        end
        if (mpend) begin
            chk(48'(media_rdata), 48'(mq.pop_front()));
        end
        if (sector_wr_q) begin
            chk(sector_lba_q, lq.pop_front());
            if (err_arm) begin
                media_err <= 1'b1;
            end
        end else if (!err_arm) begin
            media_err <= 1'b0;
        end
        rpend <= reg_rd;
        mpend <= mrd;
    end

    initial begin
        #(25 * 20000);
        num_errors++;
        print_verdict();
    end

    initial begin
        int i;
        repeat (2) @(posedge core_clk);
        nrst <= 1'b1;
        repeat (3) @(posedge core_clk);
        rd(`REG_IDENT82, 8'h01);
        rd(`REG_CMD_STAT, 8'h40);
        wr(`REG_SCOUNT, 16'h0005);
        wr(`REG_CMD_STAT, {8'h00, `CMD_TRANSLATE});
        wait_irq();
        rd(`REG_SCOUNT, 8'h00);
        rd(`REG_CMD_STAT, 8'h40);
        foreach (stby[j]) begin
            wr(`REG_CMD_STAT, {8'h00, stby[j]});
            wait_irq();
            chk(48'(sleep_q), 48'h0000_0000_0001);
            rd(`REG_CMD_STAT, 8'h40);
        end
        // The second pass carries a wrong signature and must be refused.
        for (i = 0; i < 2; i++) begin
            wr(`REG_LBA_HIGH, {8'h00, (i == 1) ? 8'h3C : `SMART_SIG_HI});
            wr(`REG_LBA_MID, {8'h00, `SMART_SIG_LO});
            wr(`REG_CMD_STAT, {8'h00, `CMD_SMART});
            wait_irq();
            chk(48'(sleep_q), 48'h0000_0000_0000);
            rd(`REG_CMD_STAT, (i == 1) ? 8'h41 : 8'h40);
        end
        rd(`REG_FEAT_ERR, 8'h04);
        wr(`REG_CMD_STAT, {8'h00, `CMD_WR_BUF});
        for (i = 0; i < 256; i++) begin
            wbuf[i] = 16'($random(seed));
            wr(`REG_DATA, wbuf[i]);
        end
        wait_irq();
        rd(`REG_CMD_STAT, 8'h40);
        for (i = 0; i < 4; i++) begin
            mread(8'(i * 85));
        end
        wr(`REG_CONFIG, 16'h0001);
        wr(`REG_CMD_STAT, {8'h00, `CMD_WR_DMA_B});
        wait_irq();
        rd(`REG_CMD_STAT, 8'h41);
        rd(`REG_FEAT_ERR, 8'h04);
        wr(`REG_CONFIG, 16'h0000);
        wr(`REG_SCOUNT, 16'h0002);
        wr(`REG_LBA_LOW, 16'h00FF);
        wr(`REG_LBA_MID, 16'h0034);
        wr(`REG_LBA_HIGH, 16'h0012);
        wr(`REG_DRV_HEAD, 16'h0045);
        lq.push_back(48'h0000_0512_34FF);
        lq.push_back(48'h0000_0512_3500);
        wr(`REG_CMD_STAT, {8'h00, `CMD_WR_DMA_A});
        wait_irq();
        rd(`REG_CMD_STAT, 8'h40);
        rd(`REG_LBA_LOW, 8'h00);
        rd(`REG_LBA_MID, 8'h35);
        for (i = 0; i < 4; i++) begin
            wr(4'(2 + i), {8'h00, ext_prev[i]});
            wr(4'(2 + i), {8'h00, ext_cur[i]});
        end
        wr(`REG_DRV_HEAD, 16'h00E0);
        lq.push_back(48'h5678_9A03_0201);
        lq.push_back(48'h5678_9A03_0202);
        err_arm <= 1'b1;
        wr(`REG_CMD_STAT, {8'h00, `CMD_WR_DMA_EXT});
        wait_irq();
        err_arm <= 1'b0;
        rd(`REG_CMD_STAT, 8'h41);
        rd(`REG_FEAT_ERR, 8'h40);
        rd(`REG_LBA_LOW, 8'h02);
        wr(`REG_DEV_CTRL, 16'h0080);
        rd(`REG_LBA_LOW, 8'h9A);
        rd(`REG_LBA_LOW, 8'h02);
        repeat (3) @(posedge core_clk);
        print_verdict();
    end
endmodule
